// ---- rtl/iev_pkg.sv ----
// Package of constants for the two-wire controller event block
// ============================================================
package iev_pkg;
	// ============================================================
	// Bus geometry
	localparam int IEV_AW = 8;
	localparam int IEV_DW = 32;
	localparam int IEV_NFLAG = 7;

	// ============================================================
	// Register byte offsets
	localparam logic [IEV_AW-1:0] OFS_OWN = 8'h00;
	localparam logic [IEV_AW-1:0] OFS_IEN = 8'h04;
	localparam logic [IEV_AW-1:0] OFS_STAT = 8'h08;
	localparam logic [IEV_AW-1:0] OFS_RXH = 8'h18;
	localparam logic [IEV_AW-1:0] OFS_TXH = 8'h20;
	localparam logic [IEV_AW-1:0] OFS_MODE = 8'h24;
	localparam logic [IEV_AW-1:0] OFS_ISR = 8'h28;
	localparam logic [IEV_AW-1:0] OFS_EMODE = 8'h2c;
	localparam logic [IEV_AW-1:0] OFS_PFUNC = 8'h48;
	localparam logic [IEV_AW-1:0] OFS_PDIR = 8'h4c;
	localparam logic [IEV_AW-1:0] OFS_PDIN = 8'h50;
	localparam logic [IEV_AW-1:0] OFS_PDOUT = 8'h54;

	// ============================================================
	// Status flag positions; the source code of a flag is its index plus one
	localparam int FL_AL = 0;
	localparam int FL_NACK = 1;
	localparam int FL_REG_ACCESS_READY_FLAG = 2;
	localparam int FL_RRDY = 3;
	localparam int FL_XRDY = 4;
	localparam int FL_SCD = 5;
	localparam int FL_AAS = 6;
	// Flags that a source read leaves alone
	localparam logic [IEV_NFLAG-1:0] W1C_ONLY = 7'h1c;

	// ============================================================
	// Field positions
	localparam int MODE_RUN_BIT = 5;
	localparam int EMODE_TSEL_BIT = 0;
	localparam int PFUNC_GPIO_BIT = 0;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;

	// ============================================================
	// Reset values
	localparam logic [6:0] OWN_RST = 7'h00;
	localparam logic [IEV_NFLAG-1:0] IEN_RST = 7'h00;
	localparam logic [IEV_NFLAG-1:0] FLAGS_RST = 7'h00;
	localparam logic TSEL_RST = 1'b1;
	localparam logic [1:0] PIN_RST = 2'h0;
endpackage

// ---- rtl/iev_top.sv ----
// Event generation for a two-wire controller: flags, source arbiter, DMA, pins
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module iev_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [iev_pkg::IEV_AW-1:0] paddr,
	input wire logic [iev_pkg::IEV_DW-1:0] pwdata,
	output logic [iev_pkg::IEV_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sda_in,
	input wire logic scl_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic core_tx_copy,
	input wire logic core_rx_copy,
	input wire logic core_access_done,
	input wire logic core_ctl_tx,
	input wire logic core_nack,
	input wire logic core_arb_lost,
	input wire logic core_sda_low,
	input wire logic core_scl_low,
	output logic [7:0] tx_shift_data,
	output logic module_run_bit,
	output logic tgt_tx_mode,
	output logic irq,
	output logic rx_dma_request,
	output logic tx_dma_request
);
	import iev_pkg::*;

	// ============================================================
	// Line watcher
	logic w_sda, w_scl, w_start, w_stop, w_hit, w_rw, w_gc;
	logic w_done, w_ack, w_nack;
	logic [7:0] w_byte;
	logic [6:0] own_ff;

	iev_watch u_watch (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.sda_pin(sda_in),
		.scl_pin(scl_in),
		.own_addr(own_ff),
		.sda_lvl(w_sda),
		.scl_lvl(w_scl),
		.start_p(w_start),
		.stop_p(w_stop),
		.addr_hit_p(w_hit),
		.addr_rw(w_rw),
		.gen_call(w_gc),
		.byte_done_p(w_done),
		.ack_p(w_ack),
		.nack_p(w_nack),
		.rx_byte(w_byte)
	);

	// ============================================================
	// Bus slave and configuration
	logic [IEV_NFLAG-1:0] ien_ff, nxt_ien;
	logic [6:0] nxt_own;
	logic [7:0] txh_ff, nxt_txh;
	logic run_ff, nxt_run, tsel_ff, nxt_tsel, gpio_ff, nxt_gpio;
	logic [1:0] pdir_ff, nxt_pdir, pdout_ff, nxt_pdout;
	logic pready_ff, nxt_pready, perr_ff, nxt_perr;
	logic [IEV_DW-1:0] prdata_ff, nxt_prdata;
	logic [IEV_NFLAG-1:0] flags_ff;
	logic [7:0] rxh_ff;
	logic [2:0] isr_ff;
	logic acc, wr, rd, mapped;
	logic [IEV_DW-1:0] rval;

	// One wait state so read data can come straight from a flop
	always_comb begin
		acc = psel & penable & pready_ff;
		wr = acc & pwrite;
		rd = acc & ~pwrite;
		mapped = 1'b1;
		rval = '0;
		case (paddr)
			OFS_OWN: rval[6:0] = own_ff;
			OFS_IEN: rval[IEV_NFLAG-1:0] = ien_ff;
			OFS_STAT: rval[IEV_NFLAG-1:0] = flags_ff;
			OFS_RXH: rval[7:0] = rxh_ff;
			OFS_TXH: rval[7:0] = txh_ff;
			OFS_MODE: rval[MODE_RUN_BIT] = run_ff;
			OFS_ISR: rval[2:0] = isr_ff;
			OFS_EMODE: rval[EMODE_TSEL_BIT] = tsel_ff;
			OFS_PFUNC: rval[PFUNC_GPIO_BIT] = gpio_ff;
			OFS_PDIR: rval[1:0] = pdir_ff;
			OFS_PDIN: rval[1:0] = {w_sda, w_scl};
			OFS_PDOUT: rval[1:0] = pdout_ff;
			default: mapped = 1'b0;
		endcase
		nxt_pready = psel & penable & ~pready_ff;
		nxt_prdata = (nxt_pready & ~pwrite) ? rval : '0;
		nxt_perr = nxt_pready & ~mapped;
		nxt_own = own_ff;
		nxt_ien = ien_ff;
		nxt_txh = txh_ff;
		nxt_run = run_ff;
		nxt_tsel = tsel_ff;
		nxt_gpio = gpio_ff;
		nxt_pdir = pdir_ff;
		nxt_pdout = pdout_ff;
		if (wr) begin
			case (paddr)
				OFS_OWN: nxt_own = pwdata[6:0];
				OFS_IEN: nxt_ien = pwdata[IEV_NFLAG-1:0];
				OFS_TXH: nxt_txh = pwdata[7:0];
				OFS_MODE: nxt_run = pwdata[MODE_RUN_BIT];
				OFS_EMODE: nxt_tsel = pwdata[EMODE_TSEL_BIT];
				OFS_PFUNC: nxt_gpio = pwdata[PFUNC_GPIO_BIT];
				OFS_PDIR: nxt_pdir = pwdata[1:0];
				OFS_PDOUT: nxt_pdout = pwdata[1:0];
				default: nxt_run = run_ff;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_ff <= OWN_RST;
			ien_ff <= IEN_RST;
			txh_ff <= 8'h00;
			run_ff <= 1'b0;
			tsel_ff <= TSEL_RST;
			gpio_ff <= 1'b0;
			pdir_ff <= PIN_RST;
			pdout_ff <= PIN_RST;
			pready_ff <= 1'b0;
			prdata_ff <= '0;
			perr_ff <= 1'b0;
		end else if (pce) begin
			own_ff <= nxt_own;
			ien_ff <= nxt_ien;
			txh_ff <= nxt_txh;
			run_ff <= nxt_run;
			tsel_ff <= nxt_tsel;
			gpio_ff <= nxt_gpio;
			pdir_ff <= nxt_pdir;
			pdout_ff <= nxt_pdout;
			pready_ff <= nxt_pready;
			prdata_ff <= nxt_prdata;
			perr_ff <= nxt_perr;
		end
	end

	// ============================================================
	// Events, flags and source arbiter
	logic [IEV_NFLAG-1:0] nxt_flags, fset, fclr, pend;
	logic [7:0] nxt_rxh, txs_ff, nxt_txs;
	logic [2:0] nxt_isr;
	logic tgt_tx_ff, nxt_tgt_tx, tgt_rx_ff, nxt_tgt_rx;
	logic irq_ff, nxt_irq, rxd_ff, nxt_rxd, txd_ff, nxt_txd;
	logic own_read, tcopy, tx_move, rx_move;

	always_comb begin
		own_read = w_hit & w_rw & ~w_gc;
		// Target-transmitter entered on own address with read, left on stop,
		// restart, refused byte or lost arbitration
		nxt_tgt_tx = tgt_tx_ff;
		if (!run_ff || w_start || w_stop || core_arb_lost || (tgt_tx_ff && w_nack))
			nxt_tgt_tx = 1'b0;
		else if (own_read)
			nxt_tgt_tx = 1'b1;
		// Arbitration loss leaves the block listening as target-receiver
		nxt_tgt_rx = tgt_rx_ff;
		if (!run_ff || w_start || w_stop)
			nxt_tgt_rx = 1'b0;
		else if (core_arb_lost || (w_hit && !w_rw))
			nxt_tgt_rx = 1'b1;
		// Timing bit only consulted while target-transmitter
		tcopy = own_read
			| (tgt_tx_ff & (tsel_ff ? w_done
			: w_ack));
		tx_move = run_ff & (core_tx_copy | tcopy);
		rx_move = run_ff & (core_rx_copy | (tgt_rx_ff & w_done));
		nxt_txs = tx_move ? txh_ff : txs_ff;
		nxt_rxh = rx_move ? w_byte : rxh_ff;
		fset = '0;
		fset[FL_AL] = core_arb_lost;
		fset[FL_NACK] = core_nack & core_ctl_tx;
		fset[FL_REG_ACCESS_READY_FLAG] = core_access_done;
		fset[FL_RRDY] = rx_move;
		fset[FL_XRDY] = tx_move;
		fset[FL_SCD] = w_stop;
		fset[FL_AAS] = w_hit;
		// Write one clears any flag; a source read clears only the others
		fclr = (wr && paddr == OFS_STAT) ? pwdata[IEV_NFLAG-1:0] : '0;
		// Clear the code the read returned, even if a newer flag has since won
		if (rd && paddr == OFS_ISR && prdata_ff[2:0] != 3'h0)
			fclr[prdata_ff[2:0] - 3'h1] = ~W1C_ONLY[prdata_ff[2:0] - 3'h1];
		// A same-cycle event beats the clear so nothing is lost
		nxt_flags = run_ff ? ((flags_ff & ~fclr) | fset) : FLAGS_RST;
		pend = nxt_flags & ien_ff;
		nxt_isr = 3'h0;
		for (int i = IEV_NFLAG - 1; i >= 0; i--) begin
			if (pend[i])
				nxt_isr = 3'(i + 1);
		end
		nxt_irq = |pend;
		// Single pulse per word keeps DMA counts exact
		nxt_rxd = rx_move;
		nxt_txd = tx_move;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= FLAGS_RST;
			rxh_ff <= 8'h00;
			txs_ff <= 8'h00;
			isr_ff <= 3'h0;
			tgt_tx_ff <= 1'b0;
			tgt_rx_ff <= 1'b0;
			irq_ff <= 1'b0;
			rxd_ff <= 1'b0;
			txd_ff <= 1'b0;
		end else if (pce) begin
			flags_ff <= nxt_flags;
			rxh_ff <= nxt_rxh;
			txs_ff <= nxt_txs;
			isr_ff <= nxt_isr;
			tgt_tx_ff <= nxt_tgt_tx;
			tgt_rx_ff <= nxt_tgt_rx;
			irq_ff <= nxt_irq;
			rxd_ff <= nxt_rxd;
			txd_ff <= nxt_txd;
		end
	end

	// ============================================================
	// Pin drivers; open drain so only low is ever driven in bus mode
	logic sda_o_ff, nxt_sda_o, sda_oe_ff, nxt_sda_oe;
	logic scl_o_ff, nxt_scl_o, scl_oe_ff, nxt_scl_oe;

	// GPIO takes the pins only while the module is held in reset
	always_comb begin
		nxt_sda_o = 1'b0;
		nxt_scl_o = 1'b0;
		nxt_sda_oe = 1'b1;
		nxt_scl_oe = 1'b1;
		if (run_ff) begin
			nxt_sda_oe = ~core_sda_low;
			nxt_scl_oe = ~core_scl_low;
		end else if (gpio_ff) begin
			nxt_sda_o = pdout_ff[PIN_SDA];
			nxt_scl_o = pdout_ff[PIN_SCL];
			nxt_sda_oe = ~pdir_ff[PIN_SDA];
			nxt_scl_oe = ~pdir_ff[PIN_SCL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_o_ff <= 1'b0;
			scl_o_ff <= 1'b0;
			sda_oe_ff <= 1'b1;
			scl_oe_ff <= 1'b1;
		end else if (pce) begin
			sda_o_ff <= nxt_sda_o;
			scl_o_ff <= nxt_scl_o;
			sda_oe_ff <= nxt_sda_oe;
			scl_oe_ff <= nxt_scl_oe;
		end
	end

	// ============================================================
	// Outputs, all from flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = perr_ff;
	assign sda_out = sda_o_ff;
	assign sda_oe_n = sda_oe_ff;
	assign scl_out = scl_o_ff;
	assign scl_oe_n = scl_oe_ff;
	assign tx_shift_data = txs_ff;
	assign module_run_bit = run_ff;
	assign tgt_tx_mode = tgt_tx_ff;
	assign irq = irq_ff;
	assign rx_dma_request = rxd_ff;
	assign tx_dma_request = txd_ff;
endmodule // iev_top
`default_nettype wire

// ---- rtl/iev_watch.sv ----
// Line watcher: pin synchronisers, start/stop, byte and acknowledge decode
`timescale 1ns/10ps
`default_nettype none
module iev_watch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic sda_pin,
	input wire logic scl_pin,
	input wire logic [6:0] own_addr,
	output logic sda_lvl,
	output logic scl_lvl,
	output logic start_p,
	output logic stop_p,
	output logic addr_hit_p,
	output logic addr_rw,
	output logic gen_call,
	output logic byte_done_p,
	output logic ack_p,
	output logic nack_p,
	output logic [7:0] rx_byte
);
	import iev_pkg::*;

	// ============================================================
	// Synchronisers, one per pin; stage one feeds stage two only
	logic [1:0] s1_ff;
	logic [1:0] s2_ff;
	logic [1:0] raw;
	assign raw[PIN_SCL] = scl_pin;
	assign raw[PIN_SDA] = sda_pin;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_ff[gi] <= 1'b1;
					s2_ff[gi] <= 1'b1;
				end else if (pce) begin
					s1_ff[gi] <= raw[gi];
					s2_ff[gi] <= s1_ff[gi];
				end
			end
		end
	endgenerate

	// ============================================================
	// Line decode
	logic [1:0] prev_ff, nxt_prev;
	logic [3:0] bcnt_ff, nxt_bcnt;
	logic [7:0] sh_ff, nxt_sh;
	logic aph_ff, nxt_aph;
	logic start_ff, nxt_start, stop_ff, nxt_stop;
	logic hit_ff, nxt_hit, rw_ff, nxt_rw, gc_ff, nxt_gc;
	logic done_ff, nxt_done, ack_ff, nxt_ack, nack_ff, nxt_nack;
	logic scl_rise, st_cond, sp_cond;
	logic [7:0] shifted;

	// Start and stop only count while the clock line is high
	always_comb begin
		scl_rise = s2_ff[PIN_SCL] & ~prev_ff[PIN_SCL];
		st_cond = s2_ff[PIN_SCL] & prev_ff[PIN_SCL] & prev_ff[PIN_SDA] & ~s2_ff[PIN_SDA];
		sp_cond = s2_ff[PIN_SCL] & prev_ff[PIN_SCL] & ~prev_ff[PIN_SDA] & s2_ff[PIN_SDA];
		shifted = {sh_ff[6:0], s2_ff[PIN_SDA]};
		nxt_prev = s2_ff;
		nxt_bcnt = bcnt_ff;
		nxt_sh = sh_ff;
		nxt_aph = aph_ff;
		nxt_start = st_cond;
		nxt_stop = sp_cond;
		nxt_hit = 1'b0;
		nxt_rw = rw_ff;
		nxt_gc = gc_ff;
		nxt_done = 1'b0;
		nxt_ack = 1'b0;
		nxt_nack = 1'b0;
		if (st_cond) begin
			nxt_bcnt = 4'h0;
			nxt_aph = 1'b1;
		end else if (sp_cond) begin
			nxt_bcnt = 4'h0;
			nxt_aph = 1'b0;
		end else if (scl_rise) begin
			if (bcnt_ff < 4'h8) begin
				nxt_sh = shifted;
				nxt_bcnt = bcnt_ff + 4'h1;
				if (bcnt_ff == 4'h7) begin
					if (aph_ff) begin
						nxt_rw = shifted[0];
						nxt_gc = (shifted[7:1] == 7'h00);
						nxt_hit = (shifted[7:1] == own_addr) || nxt_gc;
					end else begin
						nxt_done = 1'b1;
					end
				end
			end else begin
				// Ninth clock: acknowledge slot
				nxt_bcnt = 4'h0;
				nxt_aph = 1'b0;
				nxt_ack = ~aph_ff & ~s2_ff[PIN_SDA];
				nxt_nack = ~aph_ff & s2_ff[PIN_SDA];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff <= 2'h3;
			bcnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			aph_ff <= 1'b0;
			start_ff <= 1'b0;
			stop_ff <= 1'b0;
			hit_ff <= 1'b0;
			rw_ff <= 1'b0;
			gc_ff <= 1'b0;
			done_ff <= 1'b0;
			ack_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else if (pce) begin
			prev_ff <= nxt_prev;
			bcnt_ff <= nxt_bcnt;
			sh_ff <= nxt_sh;
			aph_ff <= nxt_aph;
			start_ff <= nxt_start;
			stop_ff <= nxt_stop;
			hit_ff <= nxt_hit;
			rw_ff <= nxt_rw;
			gc_ff <= nxt_gc;
			done_ff <= nxt_done;
			ack_ff <= nxt_ack;
			nack_ff <= nxt_nack;
		end
	end

	assign sda_lvl = prev_ff[PIN_SDA];
	assign scl_lvl = prev_ff[PIN_SCL];
	assign start_p = start_ff;
	assign stop_p = stop_ff;
	assign addr_hit_p = hit_ff;
	assign addr_rw = rw_ff;
	assign gen_call = gc_ff;
	assign byte_done_p = done_ff;
	assign ack_p = ack_ff;
	assign nack_p = nack_ff;
	assign rx_byte = sh_ff;
endmodule // iev_watch
`default_nettype wire

// ---- testbench/iev_bus_ctl.sv ----
// Behavioural controller on the two-wire bus, 48 ns link period
`timescale 1ns/10ps
`default_nettype none
module iev_bus_ctl (
	input wire logic sda_w,
	output logic sda_low,
	output logic scl_low
);
	// Lines released: pull-ups hold them high, clock stands between frames
	initial begin
		sda_low = 1'b0;
		scl_low = 1'b0;
	end
	// Data only moves while the clock is low
	task automatic bit_out(input logic b);
		sda_low = !b;
		#12 scl_low = 1'b0;
		#24 scl_low = 1'b1;
		#12;
	endtask
	task automatic bit_in(output logic b);
		sda_low = 1'b0;
		#12 scl_low = 1'b0;
		#12 b = sda_w;
		#12 scl_low = 1'b1;
		#12;
	endtask
	task automatic start();
		sda_low = 1'b1;
		#12 scl_low = 1'b1;
		#12;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#12 scl_low = 1'b0;
		#12 sda_low = 1'b0;
		#24;
	endtask
	// Byte out, then the acknowledge slot; high there means refused
	task automatic put_byte(input logic [7:0] d, output logic nak);
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(nak);
	endtask
	task automatic get_bits(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
	endtask
endmodule // iev_bus_ctl
`default_nettype wire

// ---- testbench/iev_chk.sv ----
// Port-level checker for event, pin and bus-answer timing
`timescale 1ns/10ps
`default_nettype none
module iev_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic core_tx_copy,
	input wire logic core_rx_copy,
	input wire logic core_sda_low,
	input wire logic module_run_bit,
	input wire logic tgt_tx_mode,
	input wire logic irq,
	input wire logic rx_dma_request,
	input wire logic tx_dma_request
);
	// ============================================================
	// Assertions, all in the one clock domain
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_rx_copy_dma: assert property (pce && module_run_bit && core_rx_copy |=> rx_dma_request)
		else $error("rx copy gave no dma pulse");
	chk_tx_copy_dma: assert property (pce && module_run_bit && core_tx_copy |=> tx_dma_request)
		else $error("tx copy gave no dma pulse");
	chk_rx_dma_once: assert property (rx_dma_request && !core_rx_copy |=> !rx_dma_request)
		else $error("rx dma pulse too long");
	chk_tx_dma_once: assert property (tx_dma_request && !core_tx_copy |=> !tx_dma_request)
		else $error("tx dma pulse too long");
	// Two samples of run low: a late pulse from the last run cycle is legal
	chk_quiet_off: assert property (!module_run_bit && !$past(module_run_bit) |-> !irq && !rx_dma_request && !tx_dma_request)
		else $error("activity while held in reset");
	chk_pin_bus: assert property ($past(module_run_bit) |-> sda_oe_n == !$past(core_sda_low) && !sda_out)
		else $error("sda pin not following sequencer");
	chk_tgt_first: assert property ($rose(tgt_tx_mode) |-> ##[0:2] tx_dma_request)
		else $error("no first tx event in target-transmitter");
	chk_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	chk_apb_once: assert property (pready |=> !pready)
		else $error("pready held too long");
endmodule // iev_chk

bind iev_top iev_chk iev_chk_i (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
	.penable(penable), .pready(pready), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.core_tx_copy(core_tx_copy), .core_rx_copy(core_rx_copy), .core_sda_low(core_sda_low),
	.module_run_bit(module_run_bit), .tgt_tx_mode(tgt_tx_mode), .irq(irq),
	.rx_dma_request(rx_dma_request), .tx_dma_request(tx_dma_request));
`default_nettype wire

// ---- testbench/iev_tb_top.sv ----
// Self-checking bench for the two-wire event block
`timescale 1ns/10ps
`default_nettype none
module iev_tb_top;
	import iev_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [IEV_AW-1:0] paddr;
	logic [IEV_DW-1:0] pwdata, prdata;
	logic sda_out, sda_oe_n, scl_out, scl_oe_n, irq, run, tgt_tx, rxd, txd;
	logic [4:0] cp; // tx copy, rx copy, access done, arb lost, no-ack
	logic ctl_tx, sda_lo, scl_lo, m_sda, m_scl, sda_w, scl_w, ce;
	logic [7:0] txs;
	int mismatches, samples_checked, n_rx, n_tx;

	// ============================================================
	// Open-drain wires: any low driver wins, else the pull-up
	assign sda_w = (sda_oe_n | sda_out) & !m_sda;
	assign scl_w = (scl_oe_n | scl_out) & !m_scl;

	iev_top iev_top_i (.pclk(pclk), .presetn(presetn), .pce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sda_in(sda_w),
		.scl_in(scl_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n), .core_tx_copy(cp[0]), .core_rx_copy(cp[1]),
		.core_access_done(cp[2]), .core_ctl_tx(ctl_tx), .core_nack(cp[4]),
		.core_arb_lost(cp[3]), .core_sda_low(sda_lo), .core_scl_low(scl_lo),
		.tx_shift_data(txs), .module_run_bit(run), .tgt_tx_mode(tgt_tx), .irq(irq),
		.rx_dma_request(rxd), .tx_dma_request(txd));
	iev_bus_ctl iev_bus_ctl_i (.sda_w(sda_w), .sda_low(m_sda), .scl_low(m_scl));

	// ============================================================
	// Clock and dma pulse counters
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = !pclk;
	end
	always @(posedge pclk) begin
		n_rx <= n_rx + int'(rxd);
		n_tx <= n_tx + int'(txd);
	end

	// ============================================================
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Never assumes an answer time: waits for pready, the watchdog cuts a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask
	task automatic pulse(input int i);
		@(posedge pclk) cp[i] <= 1'b1;
		@(posedge pclk) cp[i] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ============================================================
	// Scenarios
	task automatic t_regs();
		rd_chk(OFS_EMODE, 32'h1);
		rd_chk(OFS_STAT, 32'h0);
		wr(OFS_OWN, 32'h2a);
		rd_chk(OFS_OWN, 32'h2a);
		rd_chk(8'h30, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("test regs done");
	endtask
	task automatic t_core();
		int b;
		wr(OFS_MODE, 32'h20);
		wr(OFS_EMODE, 32'h0);
		wr(OFS_TXH, 32'ha5);
		ctl_tx <= 1'b1;
		b = n_tx;
		pulse(0);
		check(n_tx - b, 1);
		check({24'h0, txs}, 32'ha5);
		b = n_rx;
		pulse(1);
		check(n_rx - b, 1);
		// Clock enable low: a copy pulse must leave every flop alone
		ce <= 1'b0;
		b = n_tx;
		pulse(0);
		check(n_tx - b, 0);
		ce <= 1'b1;
		for (int i = 2; i < 5; i++) pulse(i);
		check({31'h0, irq}, 32'h0);
		rd_chk(OFS_STAT, 32'h1f);
		wr(OFS_IEN, 32'h7f);
		wait_n(2);
		check({31'h0, irq}, 32'h1);
		rd_chk(OFS_ISR, 32'h1);
		rd_chk(OFS_ISR, 32'h2);
		rd_chk(OFS_ISR, 32'h3);
		rd_chk(OFS_ISR, 32'h3);
		wr(OFS_STAT, 32'h1c);
		rd_chk(OFS_STAT, 32'h0);
		$display("test core events done");
	endtask
	task automatic t_addr();
		logic [7:0] ab [3] = '{8'h54, 8'h00, 8'h56};
		logic nk;
		for (int i = 0; i < 3; i++) begin
			wr(OFS_STAT, 32'h7f);
			iev_bus_ctl_i.start();
			iev_bus_ctl_i.put_byte(ab[i], nk);
			iev_bus_ctl_i.stop();
			wait_n(20);
			rd_chk(OFS_STAT, i == 2 ? 32'h20 : 32'h60);
		end
		$display("test address match done");
	endtask
	// Timing bit picks when later tx events come in target-transmitter
	task automatic t_tgt(input logic tm);
		int b;
		logic nk;
		logic [7:0] d;
		wr(OFS_EMODE, {31'h0, tm});
		wr(OFS_IEN, 32'h0);
		wr(OFS_STAT, 32'h7f);
		b = n_tx;
		iev_bus_ctl_i.start();
		iev_bus_ctl_i.put_byte(8'h55, nk);
		iev_bus_ctl_i.get_bits(d);
		wait_n(20);
		check({31'h0, tgt_tx}, 32'h1);
		check(n_tx - b, tm ? 2 : 1);
		check({31'h0, irq}, 32'h0);
		iev_bus_ctl_i.bit_out(1'b0);
		wait_n(20);
		check(n_tx - b, 2);
		iev_bus_ctl_i.get_bits(d);
		iev_bus_ctl_i.bit_out(1'b1);
		iev_bus_ctl_i.stop();
		wait_n(20);
		check({31'h0, tgt_tx}, 32'h0);
		wr(OFS_IEN, 32'h10);
		wait_n(2);
		check({31'h0, irq}, 32'h1);
		$display("test target tx done");
	endtask
	task automatic t_gpio();
		int b;
		sda_lo <= 1'b1;
		wait_n(3);
		check({31'h0, sda_oe_n}, 32'h0);
		sda_lo <= 1'b0;
		wr(OFS_MODE, 32'h0);
		b = n_rx;
		pulse(1);
		check(n_rx - b, 0);
		wr(OFS_PDIR, 32'h3);
		wr(OFS_PDOUT, 32'h1);
		wr(OFS_PFUNC, 32'h1);
		wait_n(2);
		check({28'h0, sda_oe_n, scl_oe_n, sda_out, scl_out}, 32'h1);
		rd_chk(OFS_PDIN, 32'h1);
		$display("test pin handover done");
	endtask

	// ============================================================
	// Verdict
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Whole run is about 1250 cycles; this limit only cuts a hang
	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, cp, ctl_tx, sda_lo, scl_lo} = '0;
		{mismatches, samples_checked, n_rx, n_tx} = '0;
		ce = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_core();
		t_addr();
		t_tgt(1'b1);
		t_tgt(1'b0);
		t_gpio();
		report_and_stop();
	end
endmodule // iev_tb_top
`default_nettype wire
